// ==== hw/scs_defines.svh ====
// Constants for the system clock source and divider block
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH
// =============================================================
// Source selection encodings
`define SCS_SEL_MAIN      3'h0
`define SCS_SEL_FAST      3'h1
`define SCS_SEL_FAST_DIV4 3'h2
`define SCS_SEL_SLOW      3'h3
`define SCS_SEL_RTC       3'h7
// =============================================================
// Divider values and PLL lock count
`define SCS_DIV_RESET     6'h0f
`define SCS_ACT_DIV_RESET 7'h10
`define SCS_DIV_MIN       7'h02
`define SCS_FAST_DIV4     2'h3
`define SCS_PLL_LOCK_CNT  13'h1200
`define SCS_ADC_DIV       5'h19
`define SCS_ADC_HALF      5'h0c
`endif

// ==== hw/scs_pkg.sv ====
// Types for the system clock source and divider block
package scs_pkg;
  // ===========================================================
  // Source levels, already oscillating square waves
  typedef struct packed {
    logic internal_fast_osc;
    logic main_crystal_osc;
    logic slow_osc;
    logic rtc_osc;
    logic pll_out;
  } scs_osc_t;

  // Base run-mode configuration
  typedef struct packed {
    logic       bypass;
    logic       pll_power_down;
    logic [1:0] osc_source_sel;
    logic [3:0] sys_clock_divisor;
    logic       use_pwm_div;
    logic [2:0] pwm_clock_divisor;
  } scs_cfg_t;

  // Extended run-mode configuration
  typedef struct packed {
    logic       ext_config_override;
    logic       bypass;
    logic       pll_power_down;
    logic [2:0] osc_source_sel_ext;
    logic [5:0] sys_clock_divisor;
  } scs_cfg_ext_t;

  // Deep-sleep configuration
  typedef struct packed {
    logic       enable;
    logic [2:0] osc_source_sel_ext;
    logic [5:0] sys_clock_divisor;
  } scs_ds_cfg_t;

  typedef enum logic [2:0] {
    SRC_MAIN, SRC_FAST, SRC_FAST_DIV4, SRC_SLOW, SRC_RTC, SRC_PLL
  } scs_src_t;

  typedef enum logic [1:0] {PLL_OFF, PLL_WAIT, PLL_LOCKED} scs_lock_t;
endpackage : scs_pkg

// ==== hw/scs_clock_gen.sv ====
// System clock source selection, division and derived clocks
//
// Overview of operation
// - Reset selects the internal fast oscillator
// - Bypass: select main, fast, fast/4, slow
// - Real-time oscillator only via extended 0x7
// - PLL fed by main osc, used unbypassed
// - Extended override beats base fields
// - Divide selected clock by field plus one
// - PLL output halved before divisor
// - Divider resets 0xF; 0x0 bypassed gives /2
// - Fast oscillator divided by four selectable
// - ADC clock derived automatically at 16 MHz
// - PWM clock is synchronous system clock division
// - Each peripheral has its own clock gate
// - Deep-sleep configuration may govern source, divisor
// - Hold oscillator until PLL lock count expires
`timescale 1ns/1ps
`include "scs_defines.svh"
module scs_clock_gen #(
  parameter int          N_PERIPH   = 8,
  parameter logic [12:0] LOCK_COUNT = `SCS_PLL_LOCK_CNT
) (
  input  wire logic                  CLOCK,
  input  wire logic                  RST_B,
  input  wire scs_pkg::scs_osc_t     OSC_IN,
  input  wire scs_pkg::scs_cfg_t     RUN_CLOCK_CONFIG,
  input  wire scs_pkg::scs_cfg_ext_t RUN_CLOCK_CONFIG_EXT,
  input  wire scs_pkg::scs_ds_cfg_t  DEEP_SLEEP_CLOCK_CONFIG,
  input  wire logic                  DEEP_SLEEP,
  input  wire logic                  ADC_ENABLE,
  input  wire logic [N_PERIPH-1:0]   PERIPH_GATE_EN,
  output logic                       SYSTEM_CLOCK,
  output logic [N_PERIPH-1:0]        PERIPH_CLOCK,
  output logic                       ADC_CLOCK,
  output logic                       PWM_CLOCK,
  output logic                       PLL_LOCKED,
  output logic                       PLL_IN_USE
);
  import scs_pkg::*;

  // ===========================================================
  // Source synchronisers and edge detection
  scs_osc_t    sync1;
  scs_osc_t    sync2;
  scs_osc_t    sync3;
  scs_osc_t    rise;

  // Two flops before any logic, a third for edges
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= OSC_IN;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign rise = sync2 & ~sync3;

  // ===========================================================
  // Fixed pre-dividers
  logic [1:0]  fast_cnt;
  logic        fast_div4_tick;
  logic        pll_half;
  logic        pll_half_tick;

  // Fast oscillator divided by four
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      fast_cnt <= 2'h0;
    end else if (rise.internal_fast_osc) begin
      fast_cnt <= fast_cnt + 2'h1;
    end
  end

  assign fast_div4_tick = rise.internal_fast_osc && (fast_cnt == `SCS_FAST_DIV4);

  // PLL output halved ahead of the divisor
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pll_half <= 1'b0;
    end else if (rise.pll_out) begin
      pll_half <= ~pll_half;
    end
  end

  assign pll_half_tick = rise.pll_out && pll_half;

  // ===========================================================
  // Effective configuration
  logic        eff_bypass;
  logic        eff_pd;
  logic [2:0]  eff_sel;
  logic [5:0]  eff_div;

  // Extended fields override base; deep sleep may override both
  always_comb begin
    eff_bypass = RUN_CLOCK_CONFIG.bypass;
    eff_pd     = RUN_CLOCK_CONFIG.pll_power_down;
    eff_sel    = {1'b0, RUN_CLOCK_CONFIG.osc_source_sel};
    eff_div    = {2'b00, RUN_CLOCK_CONFIG.sys_clock_divisor};
    if (RUN_CLOCK_CONFIG_EXT.ext_config_override) begin
      eff_bypass = RUN_CLOCK_CONFIG_EXT.bypass;
      eff_pd     = RUN_CLOCK_CONFIG_EXT.pll_power_down;
      eff_sel    = RUN_CLOCK_CONFIG_EXT.osc_source_sel_ext;
      eff_div    = RUN_CLOCK_CONFIG_EXT.sys_clock_divisor;
    end
    if (DEEP_SLEEP && DEEP_SLEEP_CLOCK_CONFIG.enable) begin
      eff_bypass = 1'b1;
      eff_sel    = DEEP_SLEEP_CLOCK_CONFIG.osc_source_sel_ext;
      eff_div    = DEEP_SLEEP_CLOCK_CONFIG.sys_clock_divisor;
    end
  end

  // Map a selection code to an oscillator source
  function automatic scs_src_t decode_src(input logic [2:0] sel);
    scs_src_t src;
    src = SRC_FAST;
    unique case (sel)
      `SCS_SEL_MAIN:      src = SRC_MAIN;
      `SCS_SEL_FAST:      src = SRC_FAST;
      `SCS_SEL_FAST_DIV4: src = SRC_FAST_DIV4;
      `SCS_SEL_SLOW:      src = SRC_SLOW;
      `SCS_SEL_RTC:       src = SRC_RTC;
      default:            src = SRC_FAST;
    endcase
    return src;
  endfunction : decode_src

  // Total divisor; minimum of two on every path
  function automatic logic [6:0] divisor_of(input logic [5:0] field);
    logic [6:0] d;
    d = {1'b0, field} + 7'h01;
    if (d < `SCS_DIV_MIN) begin
      d = `SCS_DIV_MIN;
    end
    return d;
  endfunction : divisor_of

  // ===========================================================
  // PLL lock counter on main oscillator edges
  scs_lock_t   lock_state;
  logic [12:0] lock_cnt;

  // Count down after power-up before the PLL may be used
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      lock_state <= PLL_OFF;
      lock_cnt   <= 13'h0000;
    end else if (eff_pd) begin
      lock_state <= PLL_OFF;
      lock_cnt   <= 13'h0000;
    end else begin
      unique case (lock_state)
        PLL_OFF: begin
          lock_state <= PLL_WAIT;
          lock_cnt   <= LOCK_COUNT;
        end
        PLL_WAIT: begin
          if (rise.main_crystal_osc) begin
            if (lock_cnt == 13'h0000) begin
              lock_state <= scs_pkg::PLL_LOCKED;
            end else begin
              lock_cnt <= lock_cnt - 13'h0001;
            end
          end
        end
        scs_pkg::PLL_LOCKED: lock_state <= scs_pkg::PLL_LOCKED;
      endcase
    end
  end

  // Scoped state name, as the output port of the same name hides it
  assign PLL_LOCKED = (lock_state == scs_pkg::PLL_LOCKED);

  // ===========================================================
  // Requested source and divisor
  scs_src_t    req_src;
  logic [6:0]  req_div;

  // PLL only with bypass clear, main source, and lock reached
  always_comb begin
    req_src = decode_src(eff_sel);
    req_div = divisor_of(eff_div);
    if (!eff_bypass && eff_sel == `SCS_SEL_MAIN && PLL_LOCKED) begin
      req_src = SRC_PLL;
    end
  end

  // ===========================================================
  // Active divider
  scs_src_t    act_src;
  logic [6:0]  act_div;
  logic [6:0]  div_cnt;
  logic        src_tick;
  logic        align;

  // Edge of the active source
  always_comb begin
    src_tick = 1'b0;
    unique case (act_src)
      SRC_MAIN:      src_tick = rise.main_crystal_osc;
      SRC_FAST:      src_tick = rise.internal_fast_osc;
      SRC_FAST_DIV4: src_tick = fast_div4_tick;
      SRC_SLOW:      src_tick = rise.slow_osc;
      SRC_RTC:       src_tick = rise.rtc_osc;
      SRC_PLL:       src_tick = pll_half_tick;
    endcase
  end

  // New settings taken only at the end of an output period
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      act_src <= SRC_FAST;
      act_div <= `SCS_ACT_DIV_RESET;
      div_cnt <= 7'h00;
      align   <= 1'b0;
    end else if (src_tick) begin
      if (align) begin
        align   <= 1'b0;                        // First edge of new source
      end else if (div_cnt >= act_div - 7'h01) begin
        div_cnt <= 7'h00;
        act_src <= req_src;
        act_div <= req_div;
        align   <= (req_src != act_src);        // Hold low until new source edge
      end else begin
        div_cnt <= div_cnt + 7'h01;
      end
    end
  end

  // Output high for the first half of each period
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      SYSTEM_CLOCK <= 1'b0;
      PLL_IN_USE   <= 1'b0;
    end else begin
      SYSTEM_CLOCK <= !align && (div_cnt < {1'b0, act_div[6:1]});
      PLL_IN_USE   <= (act_src == SRC_PLL);
    end
  end

  // ===========================================================
  // Peripheral gates
  logic [N_PERIPH-1:0] gate;

  // Enables change only while the system clock is low
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      gate         <= '0;
      PERIPH_CLOCK <= '0;
    end else begin
      if (!SYSTEM_CLOCK) begin
        gate <= PERIPH_GATE_EN;
      end
      PERIPH_CLOCK <= {N_PERIPH{SYSTEM_CLOCK}} & gate;
    end
  end

  // ===========================================================
  // ADC clock from raw PLL edges
  logic [4:0]  adc_cnt;

  // Fixed division of the PLL output down to 16 MHz
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      adc_cnt   <= 5'h00;
      ADC_CLOCK <= 1'b0;
    end else begin
      if (rise.pll_out) begin
        adc_cnt <= (adc_cnt == `SCS_ADC_DIV - 5'h01) ? 5'h00 : adc_cnt + 5'h01;
      end
      ADC_CLOCK <= ADC_ENABLE && PLL_LOCKED && (adc_cnt < `SCS_ADC_HALF);
    end
  end

  // ===========================================================
  // PWM clock
  logic        sys_prev;
  logic [7:0]  pwm_cnt;

  // Count system clock rises; tap a counter bit
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      sys_prev  <= 1'b0;
      pwm_cnt   <= 8'h00;
      PWM_CLOCK <= 1'b0;
    end else begin
      sys_prev <= SYSTEM_CLOCK;
      if (SYSTEM_CLOCK && !sys_prev) begin
        pwm_cnt <= pwm_cnt + 8'h01;            // Eight bits so every divisor code has a tap
      end
      PWM_CLOCK <= RUN_CLOCK_CONFIG.use_pwm_div ?
                   pwm_cnt[RUN_CLOCK_CONFIG.pwm_clock_divisor] : SYSTEM_CLOCK;
    end
  end
endmodule : scs_clock_gen

// ==== test/scs_clock_gen_properties.sv ====
// Port checker for the system clock source and divider block
`timescale 1ns/1ps
// ==========
// Checker
module scs_clock_gen_properties #(
  parameter int N_PERIPH = 8
) (
  input wire logic                 CLOCK,
  input wire logic                 RST_B,
  input wire scs_pkg::scs_cfg_t     RUN_CLOCK_CONFIG,
  input wire scs_pkg::scs_cfg_ext_t RUN_CLOCK_CONFIG_EXT,
  input wire logic                 ADC_ENABLE,
  input wire logic                 SYSTEM_CLOCK,
  input wire logic [N_PERIPH-1:0]  PERIPH_CLOCK,
  input wire logic                 ADC_CLOCK,
  input wire logic                 PWM_CLOCK,
  input wire logic                 PLL_LOCKED,
  input wire logic                 PLL_IN_USE
);
  import scs_pkg::*;
  scs_cfg_t     b;
  scs_cfg_ext_t e;
  logic         eff_pd;
  logic         eff_pll;
  // Effective power-down and PLL request once the override is applied
  assign b = RUN_CLOCK_CONFIG;
  assign e = RUN_CLOCK_CONFIG_EXT;
  assign eff_pd = e.ext_config_override ? e.pll_power_down : b.pll_power_down;
  assign eff_pll = e.ext_config_override ? !e.bypass && e.osc_source_sel_ext == 3'h0
                                         : !b.bypass && b.osc_source_sel == 2'h0;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // ==========
  // Properties
  sys_high_min_a: assert property ($rose(SYSTEM_CLOCK) |-> (SYSTEM_CLOCK)[*2])
    else $error("system clock high pulse too short");
  sys_low_min_a: assert property ($fell(SYSTEM_CLOCK) |-> (!SYSTEM_CLOCK)[*2])
    else $error("system clock low pulse too short");
  reset_no_pll_a: assert property ($rose(RST_B) |-> (!PLL_IN_USE)[*4])
    else $error("PLL in use right after reset");
  pll_after_lock_a: assert property ($rose(PLL_IN_USE) |-> $past(PLL_LOCKED))
    else $error("PLL taken before lock");
  pll_when_asked_a: assert property ($rose(PLL_IN_USE) |-> $past(eff_pll))
    else $error("PLL taken without bypass clear and source zero");
  powerdown_unlock_a: assert property (eff_pd |=> !PLL_LOCKED)
    else $error("lock held while powered down");
  adc_gated_a: assert property (ADC_CLOCK |-> $past(ADC_ENABLE && PLL_LOCKED))
    else $error("ADC clock without enable or lock");
  periph_from_sys_a: assert property (|PERIPH_CLOCK |-> $past(SYSTEM_CLOCK))
    else $error("peripheral clock not from system clock");
  pwm_follow_a: assert property (!b.use_pwm_div && $past(!b.use_pwm_div) |->
    PWM_CLOCK == $past(SYSTEM_CLOCK))
    else $error("undivided PWM clock not following system clock");
  // Main scenarios reached
  cover property ($rose(PLL_IN_USE));
  cover property ($rose(ADC_CLOCK));
  cover property ($rose(PWM_CLOCK) && b.use_pwm_div);
endmodule : scs_clock_gen_properties

bind scs_clock_gen scs_clock_gen_properties #(.N_PERIPH(N_PERIPH)) i_props (
  .CLOCK, .RST_B, .RUN_CLOCK_CONFIG, .RUN_CLOCK_CONFIG_EXT, .ADC_ENABLE, .SYSTEM_CLOCK,
  .PERIPH_CLOCK, .ADC_CLOCK, .PWM_CLOCK, .PLL_LOCKED, .PLL_IN_USE);

// ==== test/scs_clock_gen_tb.sv ====
// Testbench for the system clock source and divider block
`timescale 1ns/1ps
module scs_clock_gen_tb;
  import scs_pkg::*;
  // Source periods in CLOCK cycles
  localparam int PF = 4, PM = 6, PP = 4, PS = 10, PR = 14;
  logic         CLOCK, RST_B, DEEP_SLEEP, ADC_ENABLE;
  logic         SYSTEM_CLOCK, ADC_CLOCK, PWM_CLOCK, PLL_LOCKED, PLL_IN_USE;
  logic [7:0]   PERIPH_GATE_EN, PERIPH_CLOCK, seen;
  logic [3:0]   mon;
  scs_osc_t     OSC_IN;
  scs_cfg_t     RUN_CLOCK_CONFIG;
  scs_cfg_ext_t RUN_CLOCK_CONFIG_EXT;
  scs_ds_cfg_t  DEEP_SLEEP_CLOCK_CONFIG;
  int           n_mismatch = 0, compares = 0, cyc = 0, n, t;
  int           dv[4] = '{3, 0, 1, 2};
  int           ex[4] = '{PM * 4, PF * 2, PF * 8, PS * 3};
  logic [7:0]   g[2] = '{8'h05, 8'h81};
  // ==========
  // Clock, sources and timeout
  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end
  always @(negedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  assign OSC_IN = '{cyc % PF < PF / 2, cyc % PM < PM / 2, cyc % PS < PS / 2,
                    cyc % PR < PR / 2, cyc % PP < PP / 2};
  assign mon = {ADC_CLOCK, PWM_CLOCK, PERIPH_CLOCK[0], SYSTEM_CLOCK};
  scs_clock_gen #(.N_PERIPH(8), .LOCK_COUNT(13'h0004)) i_scs_clock_gen (
    .CLOCK, .RST_B, .OSC_IN, .RUN_CLOCK_CONFIG, .RUN_CLOCK_CONFIG_EXT,
    .DEEP_SLEEP_CLOCK_CONFIG, .DEEP_SLEEP, .ADC_ENABLE, .PERIPH_GATE_EN,
    .SYSTEM_CLOCK, .PERIPH_CLOCK, .ADC_CLOCK, .PWM_CLOCK, .PLL_LOCKED, .PLL_IN_USE);
  // ==========
  // Tasks
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : cmp
  task rise(input int i, inout int c);
    logic prev;
    prev = mon[i];
    @(negedge CLOCK);
    c++;
    while (!(prev === 1'b0 && mon[i] === 1'b1) && c < 1000) begin
      prev = mon[i];
      @(negedge CLOCK);
      c++;
    end
  endtask : rise
  task meas(input int i, input int exp);
    int s;
    n = 0;
    rise(i, n);
    rise(i, n);
    s = n;
    rise(i, n);
    cmp(16'(n - s), 16'(exp));
  endtask : meas
  task results();
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  // ==========
  // Sequence
  initial begin
    RST_B = 1'b0;
    DEEP_SLEEP = 1'b0;
    ADC_ENABLE = 1'b0;
    PERIPH_GATE_EN = 8'h05;
    RUN_CLOCK_CONFIG = '{1'b1, 1'b1, 2'h0, 4'hf, 1'b0, 3'h0};
    RUN_CLOCK_CONFIG_EXT = '0;
    DEEP_SLEEP_CLOCK_CONFIG = '{1'b1, 3'h3, 6'h01};
    repeat (12) @(negedge CLOCK);
    RST_B = 1'b1;
    n = 0;
    rise(0, n);
    t = n;
    rise(0, n);
    cmp(16'(n - t >= 56 && n - t <= 72), 16'h1);
    meas(0, PM * 16);
    for (int k = 0; k < 4; k++) begin
      RUN_CLOCK_CONFIG.osc_source_sel = 2'(k);
      RUN_CLOCK_CONFIG.sys_clock_divisor = 4'(dv[k]);
      meas(0, ex[k]);
    end
    RUN_CLOCK_CONFIG_EXT = '{1'b1, 1'b1, 1'b1, 3'h7, 6'h05};
    meas(0, PR * 6);
    RUN_CLOCK_CONFIG_EXT.ext_config_override = 1'b0;
    DEEP_SLEEP = 1'b1;
    meas(0, PS * 2);
    DEEP_SLEEP = 1'b0;
    RUN_CLOCK_CONFIG = '{1'b0, 1'b0, 2'h0, 4'h3, 1'b0, 3'h0};
    @(negedge CLOCK);
    cmp(16'(PLL_IN_USE), 16'h0);
    for (int k = 0; k < 200 && PLL_LOCKED !== 1'b1; k++) @(negedge CLOCK);
    cmp(16'(PLL_LOCKED), 16'h1);
    meas(0, PP * 2 * 4);
    cmp(16'(PLL_IN_USE), 16'h1);
    RUN_CLOCK_CONFIG.sys_clock_divisor = 4'h4;
    meas(0, PP * 2 * 5);
    ADC_ENABLE = 1'b1;
    meas(3, PP * 25);
    RUN_CLOCK_CONFIG.use_pwm_div = 1'b1;
    RUN_CLOCK_CONFIG.pwm_clock_divisor = 3'h1;
    meas(2, PP * 2 * 5 * 4);
    for (int k = 0; k < 2; k++) begin
      PERIPH_GATE_EN = g[k];
      meas(1, PP * 2 * 5);
      seen = 8'h00;
      repeat (40) begin
        @(negedge CLOCK);
        seen = seen | PERIPH_CLOCK;
      end
      cmp(16'(seen), 16'(g[k]));
    end
    RUN_CLOCK_CONFIG.pll_power_down = 1'b1;
    @(negedge CLOCK);
    cmp(16'(PLL_LOCKED), 16'h0);
    results();
  end
endmodule : scs_clock_gen_tb
